// >>> spimc_master.sv
// How it works
// - period is four cycles or divider plus one
// - even divisor gives 4..128 cycles, equal halves
// - odd divisor above three gives 5..127 cycles
// - odd divisor: first phase one cycle shorter than the second
// - runs only as master with phase zero
// - polarity bit picks the active clock edge
// - output data changes on the active edge, in the same cycle; the first bit after idle changes when enable falls
// - input sampled on opposite edge, slave sets up
// - enable falls half period before first edge
// - enable rises half period after last sample
// - enable stays low between back-to-back words
`timescale 1ns/1ps
module spimc_master import spimc_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [SPIMC_ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_serial_clock_pin,
  output logic o_master_out_line,
  input wire logic i_master_in_line,
  output logic o_slave_enable_n
);
  // ****************************************************************
  // declarations
  // ****************************************************************
  spimc_stream_if #(.W(SPIMC_WORD_W)) tx_in ();
  spimc_stream_if #(.W(SPIMC_WORD_W)) tx_out ();
  logic [3:0] len_cfg_q, len_cfg_d;
  logic pol_cfg_q, pol_cfg_d, master_q, master_d, phase_q, phase_d;
  logic [6:0] baud_q, baud_d;
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d, acc, done_rd, hit;
  logic rx_clr, en, pop;
  spimc_state_e state_q, state_d;
  logic [7:0] cnt_q, cnt_d, div_q, div_d, div_cfg, ha, hb;
  logic [3:0] bit_q, bit_d, len_q, len_d;
  logic [15:0] tx_sh_q, tx_sh_d, rx_sh_q, rx_sh_d, rx_word_q, rx_word_d, load_sh;
  logic pol_q, pol_d, sclk_d, mosi_d, ste_n_d, rx_full_q, rx_full_d, samp_q, samp_d;
  logic s1_q, s2_q, s3_q, miso_q, miso_d;
  logic [7:0] run_q;

  spimc_fifo #(.W(SPIMC_WORD_W), .DEPTH(SPIMC_FIFO_DEPTH)) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .in_s(tx_in.snk),
    .out_s(tx_out.src)
  );

  // ****************************************************************
  // apb slave
  // ****************************************************************
  assign acc = i_psel && i_penable;
  assign done_rd = acc && o_pready;
  assign rx_clr = done_rd && !i_pwrite && (i_paddr == SPIMC_RXD_OFF);
  assign tx_in.valid = done_rd && i_pwrite && (i_paddr == SPIMC_TXD_OFF);
  assign tx_in.data = i_pwdata[15:0];

  always_comb begin
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    prdata_d = 32'h0000_0000;
    hit = 1'b1;
    len_cfg_d = len_cfg_q;
    pol_cfg_d = pol_cfg_q;
    master_d = master_q;
    phase_d = phase_q;
    baud_d = baud_q;
    if (acc && !o_pready) begin
      // a word write waits here while the fifo is full
      pready_d = !(i_pwrite && (i_paddr == SPIMC_TXD_OFF) && !tx_in.ready);
      unique case (i_paddr)
        SPIMC_CFG_OFF: begin
          prdata_d[SPIMC_LEN_LSB +: SPIMC_LEN_W] = len_cfg_q;
          prdata_d[SPIMC_POL_BIT] = pol_cfg_q;
        end
        SPIMC_CTL_OFF: begin
          prdata_d[SPIMC_MASTER_BIT] = master_q;
          prdata_d[SPIMC_PHASE_BIT] = phase_q;
        end
        SPIMC_BAUD_OFF: prdata_d[SPIMC_BAUD_W-1:0] = baud_q;
        SPIMC_TXD_OFF: prdata_d = 32'h0000_0000;
        SPIMC_RXD_OFF: prdata_d[15:0] = rx_word_q;
        SPIMC_STAT_OFF: begin
          prdata_d[SPIMC_ST_BUSY] = (state_q != SPIMC_IDLE);
          prdata_d[SPIMC_ST_TXFULL] = !tx_in.ready;
          prdata_d[SPIMC_ST_TXEMPTY] = !tx_out.valid;
          prdata_d[SPIMC_ST_RXFULL] = rx_full_q;
        end
        default: hit = 1'b0;
      endcase
      pslverr_d = !hit;
    end
    if (done_rd && i_pwrite && !o_pslverr) begin
      if (i_paddr == SPIMC_CFG_OFF) begin
        len_cfg_d = i_pwdata[SPIMC_LEN_LSB +: SPIMC_LEN_W];
        pol_cfg_d = i_pwdata[SPIMC_POL_BIT];
      end
      if (i_paddr == SPIMC_CTL_OFF) begin
        master_d = i_pwdata[SPIMC_MASTER_BIT];
        phase_d = i_pwdata[SPIMC_PHASE_BIT];
      end
      if (i_paddr == SPIMC_BAUD_OFF) begin
        baud_d = i_pwdata[SPIMC_BAUD_W-1:0];
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
      len_cfg_q <= SPIMC_LEN_RST;
      pol_cfg_q <= 1'b0;
      master_q <= 1'b0;
      phase_q <= 1'b0;
      baud_q <= SPIMC_BAUD_RST;
    end else begin
      o_pready <= pready_d;
      o_pslverr <= pslverr_d;
      o_prdata <= prdata_d;
      len_cfg_q <= len_cfg_d;
      pol_cfg_q <= pol_cfg_d;
      master_q <= master_d;
      phase_q <= phase_d;
      baud_q <= baud_d;
    end
  end

  // ****************************************************************
  // input synchroniser
  // ****************************************************************
  assign miso_d = (s2_q == s3_q) ? s3_q : miso_q;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      miso_q <= 1'b0;
    end else begin
      s1_q <= i_master_in_line;
      s2_q <= s1_q;
      s3_q <= s2_q;
      miso_q <= miso_d;
    end
  end

  // ****************************************************************
  // serial engine
  // ****************************************************************
  assign en = master_q && !phase_q;
  assign div_cfg = (baud_q <= SPIMC_BAUD_SPECIAL_MAX) ? SPIMC_DIV_SPECIAL : {1'b0, baud_q} + 8'h01;
  // odd divisor: the extra cycle goes to the second phase
  assign ha = div_q >> 1;
  assign hb = div_q - ha;
  assign load_sh = tx_out.data << (4'hf - len_cfg_q);
  assign tx_out.ready = pop;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q - 8'h01;
    div_d = div_q;
    bit_d = bit_q;
    len_d = len_q;
    tx_sh_d = tx_sh_q;
    rx_sh_d = rx_sh_q;
    rx_word_d = rx_word_q;
    pol_d = pol_q;
    sclk_d = o_serial_clock_pin;
    mosi_d = o_master_out_line;
    ste_n_d = o_slave_enable_n;
    samp_d = 1'b0;
    pop = 1'b0;
    rx_full_d = rx_full_q && !rx_clr;
    unique case (state_q)
      SPIMC_IDLE: begin
        pol_d = pol_cfg_q;
        sclk_d = pol_cfg_q;
        div_d = div_cfg;
        cnt_d = cnt_q;
        if (en && tx_out.valid) begin
          pop = 1'b1;
          tx_sh_d = load_sh;
          mosi_d = load_sh[15];
          len_d = len_cfg_q;
          bit_d = 4'h0;
          ste_n_d = 1'b0;
          cnt_d = div_cfg - (div_cfg >> 1);
          state_d = SPIMC_LEAD;
        end
      end
      SPIMC_LEAD: begin
        if (cnt_q == 8'h01) begin
          sclk_d = !pol_q;
          cnt_d = ha;
          state_d = SPIMC_ACT;
        end
      end
      SPIMC_ACT: begin
        if (cnt_q == 8'h01) begin
          sclk_d = pol_q;
          samp_d = 1'b1;
          rx_sh_d = {rx_sh_q[14:0], miso_d};
          cnt_d = hb;
          state_d = SPIMC_INACT;
        end
      end
      SPIMC_INACT: begin
        if (cnt_q == 8'h01) begin
          cnt_d = ha;
          if (bit_q != len_q) begin
            bit_d = bit_q + 4'h1;
            tx_sh_d = tx_sh_q << 1;
            mosi_d = tx_sh_q[14];
            sclk_d = !pol_q;
            state_d = SPIMC_ACT;
          end else begin
            rx_word_d = rx_sh_q;
            rx_full_d = 1'b1;
            if (en && tx_out.valid) begin
              // next word follows at once, enable held low
              pop = 1'b1;
              tx_sh_d = load_sh;
              mosi_d = load_sh[15];
              len_d = len_cfg_q;
              bit_d = 4'h0;
              sclk_d = !pol_q;
              state_d = SPIMC_ACT;
            end else begin
              ste_n_d = 1'b1;
              state_d = SPIMC_IDLE;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= SPIMC_IDLE;
      cnt_q <= 8'h00;
      div_q <= SPIMC_DIV_SPECIAL;
      bit_q <= 4'h0;
      len_q <= SPIMC_LEN_RST;
      tx_sh_q <= 16'h0000;
      rx_sh_q <= 16'h0000;
      rx_word_q <= 16'h0000;
      rx_full_q <= 1'b0;
      pol_q <= 1'b0;
      samp_q <= 1'b0;
      o_serial_clock_pin <= 1'b0;
      o_master_out_line <= 1'b0;
      o_slave_enable_n <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      div_q <= div_d;
      bit_q <= bit_d;
      len_q <= len_d;
      tx_sh_q <= tx_sh_d;
      rx_sh_q <= rx_sh_d;
      rx_word_q <= rx_word_d;
      rx_full_q <= rx_full_d;
      pol_q <= pol_d;
      samp_q <= samp_d;
      o_serial_clock_pin <= sclk_d;
      o_master_out_line <= mosi_d;
      o_slave_enable_n <= ste_n_d;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  // length of the level currently held on clock and enable
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_q <= 8'h01;
    end else if (sclk_d != o_serial_clock_pin || ste_n_d != o_slave_enable_n) begin
      run_q <= 8'h01;
    end else if (run_q != 8'hff) begin
      run_q <= run_q + 8'h01;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_word_start;
    $fell(o_slave_enable_n);
  endsequence
  sequence s_clock_quiet;
    (o_serial_clock_pin == pol_q)[*2];
  endsequence

  a_div_select: assert property ($fell(o_slave_enable_n) |-> div_q == $past(div_cfg))
    else $error("divisor not taken from baud setting");
  a_even_halves: assert property ($changed(o_serial_clock_pin) && !o_slave_enable_n && !div_q[0]
    |-> $past(run_q) == (div_q >> 1) && div_q >= SPIMC_PER_MIN_EVEN && div_q <= SPIMC_PER_MAX_EVEN)
    else $error("even divisor half period wrong");
  a_odd_range: assert property (!o_slave_enable_n && div_q[0]
    |-> div_q >= SPIMC_PER_MIN_ODD && div_q <= SPIMC_PER_MAX_ODD)
    else $error("odd period out of range");
  a_odd_phases: assert property ($changed(o_serial_clock_pin) && !o_slave_enable_n && div_q[0]
    |-> $past(run_q) == ((o_serial_clock_pin == pol_q) ? (div_q >> 1) : div_q - (div_q >> 1)))
    else $error("odd divisor phase length wrong");
  a_mode_gate: assert property (s_word_start |-> $past(master_q) && !$past(phase_q))
    else $error("word started outside master phase zero");
  a_idle_level: assert property (o_slave_enable_n && $past(o_slave_enable_n) |-> o_serial_clock_pin == pol_q)
    else $error("idle clock level does not follow polarity");
  a_mosi_edge: assert property ($changed(o_master_out_line)
    |-> ($changed(o_serial_clock_pin) && o_serial_clock_pin != pol_q) || $fell(o_slave_enable_n))
    else $error("output data changed away from active edge");
  a_sample_edge: assert property (samp_q |-> $changed(o_serial_clock_pin) && o_serial_clock_pin == pol_q)
    else $error("input sampled on wrong edge");
  a_ste_lead: assert property (s_word_start |-> s_clock_quiet)
    else $error("clock edge too soon after enable");
  a_ste_trail: assert property ($rose(o_slave_enable_n)
    |-> $past(run_q) == div_q - (div_q >> 1) && $past(o_serial_clock_pin) == pol_q)
    else $error("enable released at wrong time");
  a_back_to_back: assert property (state_q == SPIMC_INACT && cnt_q == 8'h01 && bit_q == len_q && en
    && tx_out.valid |=> !o_slave_enable_n && state_q == SPIMC_ACT)
    else $error("enable dropped between words");
  a_cnt_bound: assert property (state_q != SPIMC_IDLE |-> cnt_q >= 8'h01 && cnt_q <= 8'h40)
    else $error("half period counter out of range");
endmodule : spimc_master

// >>> spimc_pkg.sv
package spimc_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int unsigned SPIMC_ADDR_W = 8;
  localparam logic [7:0] SPIMC_CFG_OFF = 8'h00;
  localparam logic [7:0] SPIMC_CTL_OFF = 8'h04;
  localparam logic [7:0] SPIMC_BAUD_OFF = 8'h08;
  localparam logic [7:0] SPIMC_TXD_OFF = 8'h0c;
  localparam logic [7:0] SPIMC_RXD_OFF = 8'h10;
  localparam logic [7:0] SPIMC_STAT_OFF = 8'h14;
  // ****************************************************************
  // fields and reset values
  // ****************************************************************
  localparam int unsigned SPIMC_LEN_LSB = 0;
  localparam int unsigned SPIMC_LEN_W = 4;
  localparam int unsigned SPIMC_POL_BIT = 6;
  localparam int unsigned SPIMC_MASTER_BIT = 2;
  localparam int unsigned SPIMC_PHASE_BIT = 3;
  localparam int unsigned SPIMC_BAUD_W = 7;
  localparam int unsigned SPIMC_ST_BUSY = 0;
  localparam int unsigned SPIMC_ST_TXFULL = 1;
  localparam int unsigned SPIMC_ST_TXEMPTY = 2;
  localparam int unsigned SPIMC_ST_RXFULL = 3;
  localparam logic [3:0] SPIMC_LEN_RST = 4'h7;
  localparam logic [6:0] SPIMC_BAUD_RST = 7'h03;
  // ****************************************************************
  // serial clock timing, in peripheral clock cycles
  // ****************************************************************
  localparam logic [6:0] SPIMC_BAUD_SPECIAL_MAX = 7'h02;
  localparam logic [7:0] SPIMC_DIV_SPECIAL = 8'h04;
  localparam logic [7:0] SPIMC_PER_MIN_EVEN = 8'h04;
  localparam logic [7:0] SPIMC_PER_MAX_EVEN = 8'h80;
  localparam logic [7:0] SPIMC_PER_MIN_ODD = 8'h05;
  localparam logic [7:0] SPIMC_PER_MAX_ODD = 8'h7f;
  localparam int unsigned SPIMC_WORD_W = 16;
  localparam int unsigned SPIMC_FIFO_DEPTH = 16;
  typedef enum logic [1:0] {SPIMC_IDLE, SPIMC_LEAD, SPIMC_ACT, SPIMC_INACT} spimc_state_e;
endpackage : spimc_pkg

// >>> spimc_stream_if.sv
`timescale 1ns/1ps
interface spimc_stream_if #(parameter int unsigned W = 16) ();
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src(output data, output valid, input ready);
  modport snk(input data, input valid, output ready);
endinterface : spimc_stream_if

// >>> spimc_fifo.sv
`timescale 1ns/1ps
module spimc_fifo #(
  parameter int unsigned W = 16,
  parameter int unsigned DEPTH = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  spimc_stream_if.snk in_s,
  spimc_stream_if.src out_s
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wptr_q, wptr_d, rptr_q, rptr_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_s.ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_s.valid = (cnt_q != '0);
  assign out_s.data = mem_q[rptr_q];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  always_comb begin
    wptr_d = push ? wptr_q + AW'(1) : wptr_q;
    rptr_d = pop ? rptr_q + AW'(1) : rptr_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q <= '0;
    end else begin
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
      cnt_q <= cnt_d;
    end
  end

  // storage carries no reset; the entry at the read pointer is used only while the count is nonzero
  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem_q[wptr_q] <= in_s.data;
    end
  end
endmodule : spimc_fifo

// >>> spimc_slave_model.sv
`timescale 1ns/1ps
// ****************************************************************
// far-side serial slave: phase 0, msb first
// ****************************************************************
module spimc_slave_model (
  input wire logic i_sclk,
  input wire logic i_mosi,
  input wire logic i_ste_n,
  input wire logic i_pol,
  input wire logic [3:0] i_len,
  input wire logic [15:0] i_tx_word,
  output logic o_miso,
  output logic [15:0] o_rx_word,
  output logic [15:0] o_rx_count
);
  int bit_q;
  logic [15:0] sh_q;
  initial begin
    bit_q = 0;
    sh_q = 16'h0000;
    o_miso = 1'b0;
    o_rx_word = 16'h0000;
    o_rx_count = 16'h0000;
  end
  always @(i_ste_n) begin
    bit_q = 0;
    if (i_ste_n === 1'b0) begin
      o_miso = i_tx_word[i_len];
    end else begin
      // deselected: never leave the last bit standing for the master to reuse
      o_miso = ~o_miso;
    end
  end
  always @(i_sclk) begin
    if (i_ste_n === 1'b0 && i_sclk === i_pol) begin
      sh_q = {sh_q[14:0], i_mosi};
      bit_q++;
      if (bit_q == int'(i_len) + 1) begin
        o_rx_word = sh_q;
        o_rx_count++;
        bit_q = 0;
      end
    end else if (i_ste_n === 1'b0) begin
      // new bit on the active edge, held a full period around the sampling edge
      o_miso = i_tx_word[int'(i_len) - bit_q];
    end
  end
endmodule : spimc_slave_model

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top import spimc_pkg::*; ();
  logic clk, rst_n, psel, penable, pwrite, miso, sclk, mosi, ste_n, pready, pslverr, s_pol, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] s_len;
  logic [15:0] s_tx, rx_word, rx_cnt;
  int bad_count, comparisons, ste_rises;
  logic [6:0] bauds [7] = '{7'h00, 7'h02, 7'h03, 7'h04, 7'h08, 7'h7e, 7'h7f};
  spimc_master dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_serial_clock_pin(sclk), .o_master_out_line(mosi), .i_master_in_line(miso), .o_slave_enable_n(ste_n));
  spimc_slave_model peer (.i_sclk(sclk), .i_mosi(mosi), .i_ste_n(ste_n), .i_pol(s_pol), .i_len(s_len),
    .i_tx_word(s_tx), .o_miso(miso), .o_rx_word(rx_word), .o_rx_count(rx_cnt));
  always #5 clk = ~clk;
  always @(posedge ste_n) ste_rises++;
  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // one idle cycle before each setup, so psel is never assigned twice in a step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 5000);
    if (n >= 5000) chk(32'h0, 32'h1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_for(input bit s, input logic v, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((s ? ste_n : sclk) !== v && n < 3000);
    if (n >= 3000) chk(32'h0, 32'h1);
  endtask : wait_for
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    logic [7:0] ad [5] = '{SPIMC_CFG_OFF, SPIMC_CTL_OFF, SPIMC_BAUD_OFF, SPIMC_STAT_OFF, 8'h18};
    logic [31:0] ex [5] = '{32'h7, 32'h0, 32'h3, 32'h4, 32'h0};
    chk({30'h0, sclk, ste_n}, 32'h1);
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ad[i], 32'h0);
      chk(rdat, ex[i]);
      chk(rerr, i == 4);
    end
    apb(1'b1, SPIMC_CTL_OFF, 32'h4);
    $display("t_reset done");
  endtask : t_reset
  task automatic tim(input logic [6:0] baud, input logic pol);
    int div, ha, hb, n1, n2, n;
    div = (baud <= 7'h02) ? 4 : int'(baud) + 1;
    ha = div / 2;
    hb = div - ha;
    s_pol <= pol;
    s_len <= 4'h1;
    apb(1'b1, SPIMC_CFG_OFF, {25'h0, pol, 6'h01});
    apb(1'b1, SPIMC_BAUD_OFF, {25'h0, baud});
    apb(1'b1, SPIMC_TXD_OFF, 32'h2);
    wait_for(1'b1, 1'b0, n);
    wait_for(1'b0, ~pol, n);
    chk(n, hb);
    wait_for(1'b0, pol, n1);
    chk(n1, ha);
    wait_for(1'b0, ~pol, n2);
    chk(n2, hb);
    chk(n1 + n2, div);
    wait_for(1'b0, pol, n);
    wait_for(1'b1, 1'b1, n);
    chk(n, hb);
    chk(rx_word[1:0], 2'h2);
    $display("tim baud %0d done", baud);
  endtask : tim
  task automatic t_fifo();
    int n, r0;
    logic [15:0] c0;
    s_pol <= 1'b0;
    s_len <= 4'h7;
    apb(1'b1, SPIMC_CTL_OFF, 32'h0);
    apb(1'b1, SPIMC_CFG_OFF, 32'h7);
    apb(1'b1, SPIMC_BAUD_OFF, 32'h3);
    c0 = rx_cnt;
    r0 = ste_rises;
    for (int i = 0; i < 16; i++) apb(1'b1, SPIMC_TXD_OFF, 32'h30 + i);
    apb(1'b0, SPIMC_STAT_OFF, 32'h0);
    chk(rdat, 32'ha);
    apb(1'b1, SPIMC_CTL_OFF, 32'hc);
    repeat (40) @(posedge clk);
    chk(ste_n, 1'b1);
    apb(1'b1, SPIMC_CTL_OFF, 32'h4);
    apb(1'b0, SPIMC_STAT_OFF, 32'h0);
    chk(rdat, 32'h9);
    wait_for(1'b1, 1'b0, n);
    wait_for(1'b1, 1'b1, n);
    chk(rx_cnt - c0, 16'h10);
    chk(ste_rises - r0, 1);
    chk(rx_word[7:0], 8'h3f);
    apb(1'b0, SPIMC_STAT_OFF, 32'h0);
    chk(rdat, 32'hc);
    $display("t_fifo done");
  endtask : t_fifo
  task automatic t_rx();
    int n;
    s_pol <= 1'b1;
    s_len <= 4'hf;
    s_tx <= 16'ha5c3;
    apb(1'b1, SPIMC_CFG_OFF, 32'h4f);
    // divisor 8 is the fastest receive rate software may set
    apb(1'b1, SPIMC_BAUD_OFF, 32'h7);
    apb(1'b1, SPIMC_TXD_OFF, 32'h3c5a);
    wait_for(1'b1, 1'b0, n);
    wait_for(1'b1, 1'b1, n);
    chk(rx_word, 16'h3c5a);
    apb(1'b0, SPIMC_RXD_OFF, 32'h0);
    chk(rdat, 32'ha5c3);
    apb(1'b0, SPIMC_STAT_OFF, 32'h0);
    chk(rdat, 32'h4);
    $display("t_rx done");
  endtask : t_rx
  task automatic tally_and_finish();
    $display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    s_pol = 1'b0;
    s_len = 4'h7;
    s_tx = 16'h0000;
    bad_count = 0;
    comparisons = 0;
    ste_rises = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    foreach (bauds[i]) tim(bauds[i], i[0]);
    t_fifo();
    t_rx();
    tally_and_finish();
  end
  // the whole run needs a few thousand cycles; this is far beyond it
  initial begin
    #200us;
    bad_count++;
    tally_and_finish();
  end
endmodule : tb_top
